// ### hdl/dpsm_host.v
// Host controller that drives one port of a dual-port RAM semaphore space.
// Assumes the RAM port pins connect directly; the data bus is three-state.
`timescale 1ns/1ps
`include "dpsm_regs.vh"
module dpsm_host (
    sys_clk,
    rst_n,
    cmd_valid,
    cmd_ready,
    cmd_op,
    cmd_index,
    cmd_wdata,
    rsp_valid,
    rsp_flag,
    rsp_data,
    rsp_granted,
    init_start,
    init_busy,
    ram_addr,
    ram_ce_n,
    semaphore_select_n,
    ram_rw_n,
    ram_oe_n,
    ram_data_out,
    ram_data_oe,
    ram_data_in
);
    input  wire                       sys_clk;
    input  wire                       rst_n;
    input  wire                       cmd_valid;
    output wire                       cmd_ready;
    input  wire [1:0]                 cmd_op;
    input  wire [`DPSM_SEM_IDX_W-1:0] cmd_index;
    input  wire                       cmd_wdata;
    output reg                        rsp_valid;
    output reg                        rsp_flag;
    output reg  [`DPSM_DATA_W-1:0]    rsp_data;
    output reg                        rsp_granted;
    input  wire                       init_start;
    output wire                       init_busy;
    output reg  [`DPSM_ADDR_W-1:0]    ram_addr;
    output reg                        ram_ce_n;
    output reg                        semaphore_select_n;
    output reg                        ram_rw_n;
    output reg                        ram_oe_n;
    output reg  [`DPSM_DATA_W-1:0]    ram_data_out;
    output reg                        ram_data_oe;
    input  wire [`DPSM_DATA_W-1:0]    ram_data_in;

    // ************************************************************
    // States
    // ************************************************************
    localparam [5:0] ST_IDLE  = 6'h01;
    localparam [5:0] ST_SETUP = 6'h02;
    localparam [5:0] ST_WSTRB = 6'h04;
    localparam [5:0] ST_RSTRB = 6'h08;
    localparam [5:0] ST_GAP   = 6'h10;
    localparam [5:0] ST_DONE  = 6'h20;

    reg [5:0]                 state_r;
    reg [5:0]                 state_nxt;
    reg [3:0]                 cnt_r;
    reg [3:0]                 cnt_nxt;
    reg [1:0]                 op_r;
    reg [1:0]                 op_nxt;
    reg [`DPSM_SEM_IDX_W-1:0] idx_r;
    reg [`DPSM_SEM_IDX_W-1:0] idx_nxt;
    reg                       wbit_r;
    reg                       wbit_nxt;
    reg                       is_wr_r;
    reg                       is_wr_nxt;
    reg                       init_r;
    reg                       init_nxt;
    reg [`DPSM_DATA_W-1:0]    rd_r;
    reg [`DPSM_DATA_W-1:0]    rd_nxt;

    wire [`DPSM_DATA_W-1:0]   data_sync;

    // ************************************************************
    // Data pin synchronisers
    // ************************************************************
    genvar gi;
    generate
        for (gi = 0; gi < `DPSM_DATA_W; gi = gi + 1) begin : g_sync
            dpsm_pin_sync u_sync (
                .sys_clk   (sys_clk),
                .rst_n     (rst_n),
                .pin_in    (ram_data_in[gi]),
                .level_out (data_sync[gi])
            );
        end
    endgenerate

    assign cmd_ready = state_r[0] & ~init_r;
    assign init_busy = init_r;

    wire cmd_take  = cmd_valid & cmd_ready;
    wire init_take = state_r[0] & ~init_r & init_start & ~cmd_valid;

    // ************************************************************
    // Sequencer
    // ************************************************************
    always @* begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        op_nxt    = op_r;
        idx_nxt   = idx_r;
        wbit_nxt  = wbit_r;
        is_wr_nxt = is_wr_r;
        init_nxt  = init_r;
        rd_nxt    = rd_r;
        case (state_r)
            ST_IDLE: begin
                if (cmd_take) begin
                    op_nxt    = cmd_op;
                    idx_nxt   = cmd_index;
                    // Acquire writes zero, release writes one
                    wbit_nxt  = (cmd_op == `DPSM_OP_ACQUIRE) ? 1'b0 :
                                (cmd_op == `DPSM_OP_RELEASE) ? 1'b1 : cmd_wdata;
                    is_wr_nxt = (cmd_op != `DPSM_OP_READ);
                    cnt_nxt   = `DPSM_SETUP_CYC;
                    state_nxt = ST_SETUP;
                end else if (init_take) begin
                    // Free every semaphore from this side
                    init_nxt  = 1'b1;
                    op_nxt    = `DPSM_OP_RELEASE;
                    idx_nxt   = {`DPSM_SEM_IDX_W{1'b0}};
                    wbit_nxt  = 1'b1;
                    is_wr_nxt = 1'b1;
                    cnt_nxt   = `DPSM_SETUP_CYC;
                    state_nxt = ST_SETUP;
                end
            end
            ST_SETUP: begin
                if (cnt_r == 4'h0) begin
                    cnt_nxt   = `DPSM_STROBE_CYC;
                    state_nxt = is_wr_r ? ST_WSTRB : ST_RSTRB;
                end else begin
                    cnt_nxt = cnt_r - 4'h1;
                end
            end
            ST_WSTRB: begin
                if (cnt_r == 4'h0) begin
                    cnt_nxt   = `DPSM_GAP_CYC;
                    state_nxt = ST_GAP;
                end else begin
                    cnt_nxt = cnt_r - 4'h1;
                end
            end
            ST_RSTRB: begin
                if (cnt_r == 4'h0) begin
                    rd_nxt    = data_sync;
                    cnt_nxt   = `DPSM_GAP_CYC;
                    state_nxt = ST_GAP;
                end else begin
                    cnt_nxt = cnt_r - 4'h1;
                end
            end
            ST_GAP: begin
                // Select and output enable stay high so the next read relatches
                if (cnt_r == 4'h0) begin
                    if (op_r == `DPSM_OP_ACQUIRE && is_wr_r) begin
                        // Read back after the zero write to confirm the token
                        is_wr_nxt = 1'b0;
                        cnt_nxt   = `DPSM_SETUP_CYC;
                        state_nxt = ST_SETUP;
                    end else if (init_r) begin
                        if (idx_r == `DPSM_SEM_IDX_W'h7) begin
                            init_nxt  = 1'b0;
                            state_nxt = ST_IDLE;
                        end else begin
                            idx_nxt   = idx_r + `DPSM_SEM_IDX_W'h1;
                            cnt_nxt   = `DPSM_SETUP_CYC;
                            state_nxt = ST_SETUP;
                        end
                    end else begin
                        state_nxt = ST_DONE;
                    end
                end else begin
                    cnt_nxt = cnt_r - 4'h1;
                end
            end
            ST_DONE: begin
                state_nxt = ST_IDLE;
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    // ************************************************************
    // State registers
    // ************************************************************
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= ST_IDLE;
            cnt_r   <= 4'h0;
            op_r    <= `DPSM_OP_WRITE;
            idx_r   <= {`DPSM_SEM_IDX_W{1'b0}};
            wbit_r  <= 1'b1;
            is_wr_r <= 1'b0;
            init_r  <= 1'b0;
            rd_r    <= {`DPSM_DATA_W{1'b1}};
        end else begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
            op_r    <= op_nxt;
            idx_r   <= idx_nxt;
            wbit_r  <= wbit_nxt;
            is_wr_r <= is_wr_nxt;
            init_r  <= init_nxt;
            rd_r    <= rd_nxt;
        end
    end

    // ************************************************************
    // Pin drivers
    // ************************************************************
    wire active = state_nxt[1] | state_nxt[2] | state_nxt[3];

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ram_addr           <= {`DPSM_ADDR_W{1'b0}};
            ram_ce_n           <= 1'b1;
            semaphore_select_n <= 1'b1;
            ram_rw_n           <= 1'b1;
            ram_oe_n           <= 1'b1;
            ram_data_out       <= {`DPSM_DATA_W{1'b1}};
            ram_data_oe        <= 1'b0;
        end else begin
            ram_ce_n           <= 1'b1;
            semaphore_select_n <= ~active;
            ram_addr           <= {{(`DPSM_ADDR_W-`DPSM_SEM_IDX_W){1'b0}}, idx_nxt};
            ram_rw_n           <= ~state_nxt[2];
            ram_oe_n           <= ~(state_nxt[3] | (state_nxt[1] & ~is_wr_nxt));
            ram_data_out       <= {{(`DPSM_DATA_W-1){1'b1}}, wbit_nxt};
            ram_data_oe        <= active & is_wr_nxt;
        end
    end

    // ************************************************************
    // Response
    // ************************************************************
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rsp_valid   <= 1'b0;
            rsp_flag    <= 1'b1;
            rsp_data    <= {`DPSM_DATA_W{1'b1}};
            rsp_granted <= 1'b0;
        end else begin
            rsp_valid <= state_r[5];
            if (state_r[5]) begin
                // Flag is replicated on all bits; bit zero stands for it
                rsp_data    <= rd_r;
                rsp_flag    <= rd_r[0];
                rsp_granted <= (op_r == `DPSM_OP_ACQUIRE) & ~rd_r[0];
            end
        end
    end
endmodule // dpsm_host

// ### hdl/dpsm_regs.vh
// Constants for the semaphore host controller of a dual-port RAM.
// Assumes one host port drives one side of the RAM's semaphore space.
//
// Behaviour
// - Flags are active low: write zero to request, one to release.
// - Host drives semaphore select low, uses address and write like SRAM.
// - Host holds RAM chip enable high while semaphore select is low.
// - Host deasserts select or output enable between successive reads.
// - Host acquires by writing zero first, then reading back.
// - After a failed request host reports not granted and idles; further reads or a one to withdraw come from later commands.
// - Host writes one to all semaphores on init_start to free them.
`ifndef DPSM_REGS_VH
`define DPSM_REGS_VH
`define DPSM_ADDR_W       16
`define DPSM_DATA_W       9
`define DPSM_SEM_CNT      8
`define DPSM_SEM_IDX_W    3
`define DPSM_SETUP_CYC    4'h2
`define DPSM_STROBE_CYC   4'h3
`define DPSM_GAP_CYC      4'h2
`define DPSM_OP_WRITE     2'h0
`define DPSM_OP_READ      2'h1
`define DPSM_OP_ACQUIRE   2'h2
`define DPSM_OP_RELEASE   2'h3
`endif

// ### hdl/dpsm_pin_sync.v
// Three-stage synchroniser for one pin input with agreement filter.
// Assumes the input is asynchronous to sys_clk.
`timescale 1ns/1ps
module dpsm_pin_sync (
    sys_clk,
    rst_n,
    pin_in,
    level_out
);
    input  wire sys_clk;
    input  wire rst_n;
    input  wire pin_in;
    output wire level_out;

    reg s1_r;
    reg s2_r;
    reg s3_r;
    reg lvl_r;

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_r  <= 1'b0;
            s2_r  <= 1'b0;
            s3_r  <= 1'b0;
            lvl_r <= 1'b0;
        end else begin
            s1_r <= pin_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
            if (s2_r == s3_r) begin
                lvl_r <= s3_r;
            end
        end
    end

    assign level_out = lvl_r;
endmodule // dpsm_pin_sync

// ### verification/dpsm_host_properties.sv
// Pin-level checks for the semaphore host controller.
// Assumes it is bound onto dpsm_host.
`timescale 1ns/1ps
module dpsm_host_chk (
    input logic        sys_clk,
    input logic        rst_n,
    input logic        cmd_valid,
    input logic        cmd_ready,
    input logic [1:0]  cmd_op,
    input logic        init_start,
    input logic        init_busy,
    input logic [15:0] ram_addr,
    input logic        ram_ce_n,
    input logic        semaphore_select_n,
    input logic        ram_rw_n,
    input logic        ram_oe_n,
    input logic [8:0]  ram_data_out,
    input logic        ram_data_oe
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    wire take = cmd_valid && cmd_ready;
    sequence s_wr(b);
        !ram_rw_n && !semaphore_select_n && ram_data_out[0] == b;
    endsequence
    sequence s_rd;
        !ram_oe_n && !semaphore_select_n && ram_rw_n;
    endsequence
    property p_ce; ram_ce_n; endproperty
    property p_addr; !semaphore_select_n |-> ram_addr[15:3] == 13'h0000; endproperty
    property p_wdata; ram_data_oe |-> ram_data_out[8:1] == 8'hFF; endproperty
    property p_wsel; !ram_rw_n |-> !semaphore_select_n && ram_data_oe && ram_oe_n; endproperty
    property p_start; take |=> !semaphore_select_n; endproperty
    property p_rel; take && cmd_op == 2'h3 |-> ##[1:8] s_wr(1'b1); endproperty
    property p_acq; take && cmd_op == 2'h2 |-> ##[1:8] s_wr(1'b0) ##[1:16] s_rd; endproperty
    property p_gap; $rose(semaphore_select_n) |-> semaphore_select_n[*3]; endproperty
    property p_init; init_busy && !ram_rw_n |-> ram_data_out[0]; endproperty
    a_ce: assert property (p_ce) else $error("ram enable active");
    a_addr: assert property (p_addr) else $error("upper address set");
    a_wdata: assert property (p_wdata) else $error("unused data bits low");
    a_wsel: assert property (p_wsel) else $error("write outside select");
    a_start: assert property (p_start) else $error("select late");
    a_rel: assert property (p_rel) else $error("release not one");
    a_acq: assert property (p_acq) else $error("acquire order");
    a_gap: assert property (p_gap) else $error("select gap short");
    a_init: assert property (p_init) else $error("init wrote zero");
endmodule // dpsm_host_chk

bind dpsm_host dpsm_host_chk u_chk (.sys_clk, .rst_n, .cmd_valid, .cmd_ready, .cmd_op,
    .init_start, .init_busy, .ram_addr, .ram_ce_n, .semaphore_select_n, .ram_rw_n,
    .ram_oe_n, .ram_data_out, .ram_data_oe);

// ### verification/dpsm_sem_model.sv
// Behavioural semaphore space of the dual-port RAM.
// Left port is the host pins; right port is poked by the bench.
`timescale 1ns/1ps
module dpsm_sem_model (
    input  logic [15:0] ram_addr,
    input  logic        semaphore_select_n,
    input  logic        ram_rw_n,
    input  logic        ram_oe_n,
    input  logic [8:0]  ram_data_out,
    input  logic        r_wr,
    input  logic [2:0]  r_idx,
    input  logic        r_bit,
    output logic [8:0]  ram_data_in,
    output logic [7:0]  r_flag
);
    logic [7:0] own_l = 8'hFF;  // Left owns all at power-up
    logic [7:0] own_r = 8'h00;
    logic [7:0] req_l = 8'hFF;
    logic [7:0] req_r = 8'h00;
    logic [8:0] last = 9'h000;
    wire rd_idle = semaphore_select_n | ram_oe_n;
    task automatic put(input bit left, input logic [2:0] i, input logic b);
        if (left) req_l[i] = !b; else req_r[i] = !b;
        if (own_l[i] && !req_l[i]) begin
            own_l[i] = 1'b0;
            own_r[i] = req_r[i];
        end
        if (own_r[i] && !req_r[i]) begin
            own_r[i] = 1'b0;
            own_l[i] = req_l[i];
        end
        if (!own_l[i] && !own_r[i]) begin
            own_l[i] = req_l[i];
            own_r[i] = req_r[i] && !req_l[i];
        end
    endtask
    // Write lands as the strobe opens; select, address and data are settled by then
    always @(negedge ram_rw_n) begin
        if (!semaphore_select_n) put(1'b1, ram_addr[2:0], ram_data_out[0]);
    end
    always @(posedge r_wr) put(1'b0, r_idx, r_bit);
    always @(negedge rd_idle) last = {9{~own_l[ram_addr[2:0]]}};
    assign ram_data_in = rd_idle ? ~last : last;
    assign r_flag = ~own_r;
endmodule // dpsm_sem_model

// ### verification/tb_top.sv
// Self-checking bench for the semaphore host controller.
// Assumes the behavioural semaphore model on the far side.
`timescale 1ns/1ps
module tb_top;
    logic sys_clk = 0, rst_n = 0, cmd_valid = 0, cmd_wdata = 0, init_start = 0;
    logic [1:0] cmd_op = 0;
    logic [2:0] cmd_index = 0, r_idx = 0;
    logic r_wr = 0, r_bit = 1, cmd_ready, rsp_valid, rsp_flag, rsp_granted, init_busy;
    logic ram_ce_n, semaphore_select_n, ram_rw_n, ram_oe_n, ram_data_oe;
    logic [8:0] rsp_data, ram_data_out, ram_data_in;
    logic [15:0] ram_addr;
    logic [7:0] r_flag;
    int errors = 0, cmp_count = 0, cyc = 0;
    dpsm_host u_dut (.sys_clk, .rst_n, .cmd_valid, .cmd_ready, .cmd_op, .cmd_index,
        .cmd_wdata, .rsp_valid, .rsp_flag, .rsp_data, .rsp_granted, .init_start,
        .init_busy, .ram_addr, .ram_ce_n, .semaphore_select_n, .ram_rw_n, .ram_oe_n,
        .ram_data_out, .ram_data_oe, .ram_data_in);
    dpsm_sem_model u_dev (.ram_addr, .semaphore_select_n, .ram_rw_n, .ram_oe_n,
        .ram_data_out, .r_wr, .r_idx, .r_bit, .ram_data_in, .r_flag);
    always #12.5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 3000) begin
            errors++;
            report_and_stop();
        end
    end
    task report_and_stop;
        if (errors == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task check(input logic [8:0] seen, input logic [8:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task run(input logic [1:0] op, input logic [2:0] idx, input logic b);
        @(negedge sys_clk);
        {cmd_valid, cmd_op, cmd_index, cmd_wdata} = {1'b1, op, idx, b};
        while (cmd_ready !== 1'b1) @(negedge sys_clk);
        @(negedge sys_clk);
        cmd_valid = 0;
        while (rsp_valid !== 1'b1) @(negedge sys_clk);
    endtask
    task rside(input logic [2:0] i, input logic b);
        @(negedge sys_clk);
        {r_idx, r_bit, r_wr} = {i, b, 1'b1};
        @(negedge sys_clk);
        r_wr = 0;
    endtask
    task t_init;
        @(negedge sys_clk);
        init_start = 1;
        @(negedge sys_clk);
        init_start = 0;
        while (init_busy !== 1'b0) @(negedge sys_clk);
        for (int i = 0; i < 8; i++) rside(i[2:0], 1'b1);
        run(2'h1, 3'h0, 1'b0);
        check(rsp_data, 9'h1FF);
        check(r_flag, 8'hFF);
    endtask
    task t_index;
        for (int i = 0; i < 8; i++) rside(i[2:0], i[0]);
        for (int i = 0; i < 8; i++) begin
            run(2'h2, i[2:0], 1'b0);
            check(rsp_granted, i[0]);
        end
        for (int i = 0; i < 8; i++) begin
            run(2'h3, i[2:0], 1'b1);
            rside(i[2:0], 1'b1);
        end
        check(r_flag, 8'hFF);
    endtask
    task t_pass;
        run(2'h2, 3'h5, 1'b0);
        check(rsp_data, 9'h000);
        rside(3'h5, 1'b0);
        check(r_flag[5], 1'b1);
        run(2'h3, 3'h5, 1'b1);
        check(r_flag[5], 1'b0);
        run(2'h2, 3'h5, 1'b0);
        check(rsp_granted, 1'b0);
        check(rsp_flag, 1'b1);
        run(2'h3, 3'h5, 1'b1);
        rside(3'h5, 1'b1);
        check(r_flag[5], 1'b1);
    endtask
    task t_write;
        run(2'h0, 3'h3, 1'b0);
        run(2'h1, 3'h3, 1'b0);
        check(rsp_data, 9'h000);
        run(2'h0, 3'h3, 1'b1);
        run(2'h1, 3'h3, 1'b0);
        check(rsp_data, 9'h1FF);
    endtask
    initial begin
        repeat (2) @(negedge sys_clk);
        rst_n = 1;
        t_init();
        t_index();
        t_pass();
        t_write();
        report_and_stop();
    end
endmodule // tb_top
